// >>> tb/pbvi_master.sv
`timescale 1ns/1ps
// processor-side master: holds each request until the answer is sampled
module pbvi_master (
  input wire logic sys_clk_i,
  input wire logic [7:0] data_bus_o,
  input wire logic transfer_ack_n_o,
  input wire logic transfer_ack_oe_n_o,
  output logic chip_select_n_o,
  output logic data_strobe_n_o,
  output logic read_write_o,
  output logic int_ack_n_o,
  output logic [4:0] reg_select_o,
  output logic [7:0] wdata_o
);
  // after xfer the idle bus shows the inverse of its last value; fixed_read leaves it unchanged
  initial begin
    chip_select_n_o = 1'b1;
    data_strobe_n_o = 1'b1;
    int_ack_n_o = 1'b1;
    read_write_o = 1'b1;
    reg_select_o = 5'h00;
    wdata_o = 8'h5a;
  end
  task automatic xfer(input logic int_ack_n, input logic rd, input logic [4:0] rs,
    input logic [7:0] wd, output logic [7:0] q, output logic ok);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    #2;
    read_write_o = rd;
    reg_select_o = rs;
    wdata_o = rd ? ~wdata_o : wd;
    if (int_ack_n) int_ack_n_o = 1'b0; // select stays off
    else chip_select_n_o = 1'b0;
    data_strobe_n_o = 1'b0;
    do begin
      @(posedge sys_clk_i);
      n++;
      ok = (transfer_ack_n_o === 1'b0) && (transfer_ack_oe_n_o === 1'b0);
    end while (!ok && n < 10);
    q = data_bus_o;
    #2; // strobe lifts only once the answer is taken
    data_strobe_n_o = 1'b1;
    chip_select_n_o = 1'b1;
    int_ack_n_o = 1'b1;
    wdata_o = ~wdata_o;
    n = 0;
    while (transfer_ack_oe_n_o !== 1'b1 && n < 8) begin
      @(posedge sys_clk_i);
      n++;
    end
    @(posedge sys_clk_i);
  endtask
  // fixed-length enable phase; acknowledge is not looked at
  task automatic fixed_read(input logic [4:0] rs, output logic [7:0] q);
    @(posedge sys_clk_i);
    #2;
    read_write_o = 1'b1;
    reg_select_o = rs;
    chip_select_n_o = 1'b0;
    data_strobe_n_o = 1'b0;
    repeat (6) @(posedge sys_clk_i);
    q = data_bus_o;
    #2;
    data_strobe_n_o = 1'b1;
    chip_select_n_o = 1'b1;
    repeat (4) @(posedge sys_clk_i);
  endtask
endmodule

// >>> tb/pbvi_top_properties.sv
`timescale 1ns/1ps
// watches the host port of the bus and vector block
module pbvi_checker (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic chip_select_n_i,
  input wire logic data_strobe_n_i,
  input wire logic read_write_i,
  input wire logic int_ack_n_i,
  input wire logic chain_enable_in_n_i,
  input wire logic [15:0] chan_enable_i,
  input wire logic data_bus_oe_n_o,
  input wire logic transfer_ack_n_o,
  input wire logic transfer_ack_oe_n_o,
  input wire logic int_req_n_o,
  input wire logic chain_enable_out_n_o,
  input wire logic [7:0] vector_reg_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // leaving reset, every driver is off and the vector holds its preset
  AST_RESET_STATE: assert property (
    $rose(rst_b_i) |-> vector_reg_o == pbvi_pkg::VEC_RESET && int_req_n_o
      && data_bus_oe_n_o && transfer_ack_oe_n_o)
    else $error("reset state wrong");
  // the window allows for the two synchroniser stages
  AST_READ_ACK: assert property (
    $fell(data_strobe_n_i) && !chip_select_n_i && read_write_i |->
      ##[2:6] (!transfer_ack_n_o && !transfer_ack_oe_n_o && !data_bus_oe_n_o))
    else $error("read not answered");
  AST_WRITE_ACK: assert property (
    $fell(data_strobe_n_i) && !chip_select_n_i && !read_write_i |->
      ##[2:6] (!transfer_ack_n_o && !transfer_ack_oe_n_o))
    else $error("write not answered");
  AST_ACK_END: assert property (
    $rose(data_strobe_n_i) && !transfer_ack_n_o |-> ##[1:4] transfer_ack_n_o)
    else $error("ack not ended");
  // ack is driven high for a cycle before it floats, avoiding a slow rise
  AST_ACK_FLOAT: assert property (
    $rose(transfer_ack_n_o) |-> !transfer_ack_oe_n_o && data_bus_oe_n_o
      ##1 transfer_ack_oe_n_o)
    else $error("ack release order wrong");
  AST_VEC_DRIVE: assert property (
    !int_ack_n_i && !transfer_ack_n_o && !transfer_ack_oe_n_o |->
      !data_bus_oe_n_o)
    else $error("vector ack without data");
  AST_PASS_QUIET: assert property (
    !chain_enable_out_n_o |-> data_bus_oe_n_o && transfer_ack_oe_n_o)
    else $error("drives bus while passing");
  AST_SERVE: assert property (
    $fell(int_ack_n_i) && !chain_enable_in_n_i && !int_req_n_o |->
      ##[2:6] (!transfer_ack_n_o && chain_enable_out_n_o))
    else $error("pending request not served");
  AST_PASS_ON: assert property (
    $fell(int_ack_n_i) && !chain_enable_in_n_i && int_req_n_o |->
      ##[2:6] !chain_enable_out_n_o)
    else $error("priority not passed on");
  // a higher device is being served, so chain out stays negated
  AST_CHAIN_BLOCK: assert property (
    chain_enable_in_n_i |=> chain_enable_out_n_o)
    else $error("chain out asserted under chain in");
  AST_DISABLED_QUIET: assert property (
    chan_enable_i == 16'h0000 [*3] |-> int_req_n_o)
    else $error("request with channels off");
  COV_READ: cover property (!transfer_ack_n_o && read_write_i);
  COV_VECTOR: cover property (!int_ack_n_i && !transfer_ack_n_o);
  COV_PASS: cover property (!chain_enable_out_n_o);
endmodule
bind pbvi_top pbvi_checker u_chk (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
  .chip_select_n_i(chip_select_n_i), .data_strobe_n_i(data_strobe_n_i),
  .read_write_i(read_write_i), .int_ack_n_i(int_ack_n_i),
  .chain_enable_in_n_i(chain_enable_in_n_i), .chan_enable_i(chan_enable_i),
  .data_bus_oe_n_o(data_bus_oe_n_o), .transfer_ack_n_o(transfer_ack_n_o),
  .transfer_ack_oe_n_o(transfer_ack_oe_n_o), .int_req_n_o(int_req_n_o),
  .chain_enable_out_n_o(chain_enable_out_n_o), .vector_reg_o(vector_reg_o));

// >>> tb/periph_bus_and_vectored_irq_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) \
  begin \
    total_checks++; \
    if ((a) !== (e)) begin \
      error_cnt++; \
      $display("ERROR %s expected %h seen %h", nm, e, a); \
    end \
  end
module periph_bus_and_vectored_irq_bench;
  logic sys_clk_i, rst_b_i, cs_n, ds_n, rw, int_ack_n_n, cin_n;
  logic [4:0] rs;
  logic [7:0] wd, gp, ireq, dout, vreg, q;
  logic [15:0] en;
  logic doe_n, ack_n, ack_oe_n, irq_n, cout_n, ok;
  int error_cnt = 0;
  int total_checks = 0;
  // vector codes: gp lines 0..7, then internal request bits 0..7
  logic [3:0] code [16] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'he, 4'hf,
    4'h4, 4'h5, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd};
  pbvi_top dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .chip_select_n_i(cs_n), .data_strobe_n_i(ds_n), .read_write_i(rw),
    .int_ack_n_i(int_ack_n_n), .chain_enable_in_n_i(cin_n), .reg_select_i(rs),
    .data_bus_i(wd), .gp_int_lines_i(gp), .internal_req_i(ireq),
    .chan_enable_i(en), .data_bus_o(dout), .data_bus_oe_n_o(doe_n),
    .transfer_ack_n_o(ack_n), .transfer_ack_oe_n_o(ack_oe_n),
    .int_req_n_o(irq_n), .chain_enable_out_n_o(cout_n), .vector_reg_o(vreg));
  pbvi_master m (.sys_clk_i(sys_clk_i), .data_bus_o(dout),
    .transfer_ack_n_o(ack_n), .transfer_ack_oe_n_o(ack_oe_n),
    .chip_select_n_o(cs_n), .data_strobe_n_o(ds_n), .read_write_o(rw),
    .int_ack_n_o(int_ack_n_n), .reg_select_o(rs), .wdata_o(wd));
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    m.xfer(1'b0, 1'b0, a, d, q, ok);
    `CHK("write ack", 1'b1, ok)
  endtask
  task automatic int_ack_n(input logic [3:0] c);
    m.xfer(1'b1, 1'b0, 5'h00, 8'h00, q, ok);
    `CHK("vector ack", 1'b1, ok)
    `CHK("vector", {4'ha, c}, q)
  endtask
  // gp lines set pending on a rising edge, internal bits on a pulse
  task automatic raise(input int s);
    @(posedge sys_clk_i);
    #2;
    if (s < 8) gp[s] = 1'b1;
    else ireq[s-8] = 1'b1;
    @(posedge sys_clk_i);
    #2 ireq = 8'h00;
    repeat (4) @(posedge sys_clk_i);
    #2 gp = 8'h00;
    repeat (4) @(posedge sys_clk_i);
  endtask
  task automatic t_regs();
    `CHK("vector reset", pbvi_pkg::VEC_RESET, vreg)
    `CHK("irq reset", 1'b1, irq_n)
    m.fixed_read(5'h1f, q); // dummy access before real ones
    `CHK("dummy read", 8'h00, q)
    wr(pbvi_pkg::RSEL_MASK_HI, 8'hff);
    wr(pbvi_pkg::RSEL_MASK_LO, 8'hff);
    wr(pbvi_pkg::RSEL_VECTOR, 8'ha5);
    m.xfer(1'b0, 1'b1, pbvi_pkg::RSEL_VECTOR, 8'h00, q, ok);
    `CHK("vector read", 8'haf, q)
    m.fixed_read(pbvi_pkg::RSEL_VECTOR, q);
    `CHK("enable-phase read", 8'haf, q)
    m.xfer(1'b0, 1'b1, 5'h1f, 8'h00, q, ok);
    `CHK("unmapped read", 8'h00, q)
    $display("test regs done");
  endtask
  // every source alone: its own code, request drops once served
  task automatic t_codes();
    for (int s = 0; s < 16; s++) begin
      raise(s);
      `CHK("irq set", 1'b0, irq_n)
      int_ack_n(code[s]);
      repeat (3) @(posedge sys_clk_i);
      `CHK("irq clear", 1'b1, irq_n)
    end
    $display("test codes done");
  endtask
  task automatic t_prio();
    raise(0);
    raise(15);
    raise(7);
    int_ack_n(4'hf);
    `CHK("irq held", 1'b0, irq_n)
    int_ack_n(4'hd);
    int_ack_n(4'h0);
    $display("test prio done");
  endtask
  task automatic t_mask();
    raise(7);
    raise(0);
    wr(pbvi_pkg::RSEL_MASK_HI, 8'h00);
    int_ack_n(4'h0);
    wr(pbvi_pkg::RSEL_MASK_HI, 8'hff);
    int_ack_n(4'hf);
    raise(1);
    #2 en = 16'h0000;
    repeat (4) @(posedge sys_clk_i);
    #2 en = 16'hffff;
    repeat (3) @(posedge sys_clk_i);
    `CHK("irq after disable", 1'b1, irq_n)
    $display("test mask done");
  endtask
  task automatic t_chain();
    m.xfer(1'b1, 1'b0, 5'h00, 8'h00, q, ok);
    `CHK("no ack when idle", 1'b0, ok)
    raise(2);
    #2 cin_n = 1'b1;
    m.xfer(1'b1, 1'b0, 5'h00, 8'h00, q, ok);
    `CHK("no ack chain high", 1'b0, ok)
    // the released int_ack must reach the synchronised side first
    repeat (2) @(posedge sys_clk_i);
    #2 cin_n = 1'b0;
    int_ack_n(4'h2);
    $display("test chain done");
  endtask
  // mid-run reset: preset vector returns, masks and pending are lost
  task automatic t_reset();
    raise(3);
    `CHK("irq before reset", 1'b0, irq_n)
    #2 rst_b_i = 1'b0;
    repeat (40) @(posedge sys_clk_i); // two microseconds
    #2 rst_b_i = 1'b1;
    `CHK("vector after reset", pbvi_pkg::VEC_RESET, vreg)
    `CHK("irq after reset", 1'b1, irq_n)
    raise(3);
    `CHK("masked after reset", 1'b1, irq_n)
    $display("test reset done");
  endtask
  initial begin
    rst_b_i = 1'b0;
    cin_n = 1'b0; // top of chain
    gp = 8'h00;
    ireq = 8'h00;
    en = 16'hffff;
    repeat (12) @(posedge sys_clk_i);
    #2 rst_b_i = 1'b1;
    t_regs();
    t_codes();
    t_prio();
    t_mask();
    t_chain();
    t_reset();
    conclude();
  end
  // the tests need well under 5000 cycles
  initial begin
    #500000;
    error_cnt++;
    conclude();
  end
endmodule

// >>> verilog/pbvi_pkg.sv
package pbvi_pkg;
  localparam int NUM_CH = 16;
  localparam int CH_W = 4;
  localparam int RSEL_W = 5;
  localparam int DATA_W = 8;
  // vector register loads this after reset
  localparam logic [7:0] VEC_RESET = 8'h0f;
  // register select index of the vector register in this block
  localparam logic [4:0] RSEL_VECTOR = 5'h0b;
  // pending register halves, high channels and low channels
  localparam logic [4:0] RSEL_PEND_HI = 5'h05;
  localparam logic [4:0] RSEL_PEND_LO = 5'h06;
  localparam logic [4:0] RSEL_MASK_HI = 5'h09;
  localparam logic [4:0] RSEL_MASK_LO = 5'h0a;
  // synchroniser depth for the asynchronous bus strobes
  localparam int SYNC_STAGES = 2;
  typedef enum logic [2:0] {
    PBVI_IDLE  = 3'b000,
    PBVI_DRIVE = 3'b001,
    PBVI_ACK   = 3'b010,
    PBVI_HIGH  = 3'b011,
    PBVI_PASS  = 3'b100
  } pbvi_state_t;
endpackage

// >>> verilog/pbvi_sync.sv
`timescale 1ns/1ps
// two-stage level synchroniser, first stage read only by the second
module pbvi_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  // metastability guard; reset to the idle (negated) level
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

// >>> verilog/pbvi_top.sv
`timescale 1ns/1ps
// Functional notes
// - read with select and strobe drives selected register, then acknowledge.
// - read ends on select or strobe release; ack driven high then released.
// - write with select and strobe loads selected register, then acknowledge.
// - write ends on select or strobe release; ack high then released.
// - interrupt request asserted low whenever any of 16 channels is pending and unmasked.
// - acknowledge cycle drives vector on low byte and asserts acknowledge.
// - strobe or int_ack release ends cycle: ack high, released, bus off.
// - request negates after acknowledge unless more requests remain.
// - chain input low: vector if pending, otherwise assert chain output.
// - when passing priority, drive neither data bus nor acknowledge.
// - reset clears registers except vector; channels off, pending cleared.
// - reset negates outputs, floats bus and loads vector with 0Fh.
// - sixteen channels fixed priority; vector of highest pending one.
// - line seven is 1111 highest, line zero 0000 lowest, others mapped.
// - internal channels timer A 1101 down to timer D 0100.
// - masked channels are skipped, so masking re-orders service.
// - vector is base nibble from register over four-bit channel code.
// - returning a vector clears the acknowledged channel's pending bit.
module pbvi_top (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic chip_select_n_i,
  input wire logic data_strobe_n_i,
  input wire logic read_write_i,
  input wire logic int_ack_n_i,
  input wire logic chain_enable_in_n_i,
  input wire logic [4:0] reg_select_i,
  input wire logic [7:0] data_bus_i,
  input wire logic [7:0] gp_int_lines_i,
  input wire logic [7:0] internal_req_i,
  input wire logic [15:0] chan_enable_i,
  output logic [7:0] data_bus_o,
  output logic data_bus_oe_n_o,
  output logic transfer_ack_n_o,
  output logic transfer_ack_oe_n_o,
  output logic int_req_n_o,
  output logic chain_enable_out_n_o,
  output logic [7:0] vector_reg_o
);
  // internal_req_i bit order: timer A, receive full, receive error,
  // transmit empty, transmit error, timer B, timer C, timer D (bit 7..0)
  logic cs_s;
  logic ds_s;
  logic int_ack_n_s;
  logic [7:0] gp_s;
  logic [7:0] gp_prev_q;
  logic [15:0] chan_req;
  logic [15:0] pend_q;
  logic [15:0] mask_q;
  logic [15:0] live;
  logic any_live;
  logic [3:0] top_code;
  logic [7:0] vec_q;
  logic [7:0] rdata;
  logic rw_q;
  logic [4:0] rsel_q;
  logic bus_req;
  logic int_ack_n_req;
  logic [15:0] clr_pend;
  logic wr_pulse;
  logic ack_pulse;
  logic access_end;
  pbvi_pkg::pbvi_state_t state_q;
  pbvi_pkg::pbvi_state_t state_d;

  // two stages cost two cycles of latency but keep metastability out
  // strobes cross in before use, so each access acts once
  pbvi_sync #(
    .WIDTH(3),
    .RST_VAL(3'h7)
  ) u_sync_ctl (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .async_i({chip_select_n_i, data_strobe_n_i, int_ack_n_i}),
    .sync_o({cs_s, ds_s, int_ack_n_s})
  );

  // general-purpose lines are asynchronous too
  pbvi_sync #(
    .WIDTH(8),
    .RST_VAL(8'h00)
  ) u_sync_gp (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .async_i(gp_int_lines_i),
    .sync_o(gp_s)
  );

  // a register access needs select and strobe, a vector cycle int_ack
  // select and acknowledge are never both low by contract
  assign bus_req = !cs_s && !ds_s;
  assign int_ack_n_req = !int_ack_n_s && !ds_s;

  // either strobe released ends the access
  assign access_end = (cs_s && int_ack_n_s) || ds_s;

  // rising edge detect on general-purpose lines
  // reset low like the synchronised idle level, so no false edge follows
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gp_prev_q <= 8'h00;
    end else begin
      gp_prev_q <= gp_s;
    end
  end

  // map sources onto channel numbers by position in the vector
  always_comb begin
    chan_req = 16'h0000;
    chan_req[15] = gp_s[7] && !gp_prev_q[7];
    chan_req[14] = gp_s[6] && !gp_prev_q[6];
    chan_req[13] = internal_req_i[7]; // timer A
    chan_req[12] = internal_req_i[6]; // receive full
    chan_req[11] = internal_req_i[5]; // receive error
    chan_req[10] = internal_req_i[4]; // transmit empty
    chan_req[9] = internal_req_i[3]; // transmit error
    chan_req[8] = internal_req_i[2]; // timer B
    chan_req[7] = gp_s[5] && !gp_prev_q[5];
    chan_req[6] = gp_s[4] && !gp_prev_q[4];
    chan_req[5] = internal_req_i[1]; // timer C
    chan_req[4] = internal_req_i[0]; // timer D
    chan_req[3] = gp_s[3] && !gp_prev_q[3];
    chan_req[2] = gp_s[2] && !gp_prev_q[2];
    chan_req[1] = gp_s[1] && !gp_prev_q[1];
    chan_req[0] = gp_s[0] && !gp_prev_q[0];
    chan_req = chan_req & chan_enable_i;
  end

  // only unmasked pending channels compete
  assign live = pend_q & mask_q;
  assign any_live = |live;

  // fixed priority: highest channel number wins
  // the scan runs upward, so the last hit is the highest live channel
  always_comb begin
    top_code = 4'h0;
    for (int i = 0; i < pbvi_pkg::NUM_CH; i++) begin
      if (live[i]) begin
        top_code = i[3:0];
      end
    end
  end

  // bus state machine
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      pbvi_pkg::PBVI_IDLE: begin
        if (bus_req) begin
          state_d = pbvi_pkg::PBVI_DRIVE;
        end else if (int_ack_n_req && !chain_enable_in_n_i) begin
          // chain in high means a higher device answers: stay silent
          // and keep chain out negated until chain in falls
          if (any_live) begin
            state_d = pbvi_pkg::PBVI_DRIVE;
          end else begin
            state_d = pbvi_pkg::PBVI_PASS;
          end
        end
      end
      pbvi_pkg::PBVI_DRIVE: begin
        state_d = pbvi_pkg::PBVI_ACK;
      end
      pbvi_pkg::PBVI_ACK: begin
        // release of either strobe ends the cycle
        if (access_end) begin
          state_d = pbvi_pkg::PBVI_HIGH;
        end
      end
      pbvi_pkg::PBVI_HIGH: begin
        state_d = pbvi_pkg::PBVI_IDLE;
      end
      pbvi_pkg::PBVI_PASS: begin
        // a rising chain in takes the priority back at once
        if (!int_ack_n_req || chain_enable_in_n_i) begin
          state_d = pbvi_pkg::PBVI_IDLE;
        end
      end
      default: begin
        state_d = pbvi_pkg::PBVI_IDLE;
      end
    endcase
  end

  // state register of the bus machine
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= pbvi_pkg::PBVI_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // latch direction and select at the start of an access
  // rests at read outside an access, so a vector cycle never writes
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rw_q <= 1'b1;
      rsel_q <= 5'h00;
    end else if (state_q == pbvi_pkg::PBVI_IDLE) begin
      rw_q <= read_write_i || !bus_req;
      rsel_q <= reg_select_i;
    end
  end

  assign wr_pulse = state_q == pbvi_pkg::PBVI_DRIVE && !rw_q && int_ack_n_s;
  assign ack_pulse = state_q == pbvi_pkg::PBVI_DRIVE && !int_ack_n_s;

  // vector register keeps 0Fh after reset; lower nibble not writable
  // only the base nibble reaches the vector, the rest is constant
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vec_q <= pbvi_pkg::VEC_RESET;
    end else if (wr_pulse && rsel_q == pbvi_pkg::RSEL_VECTOR) begin
      vec_q <= {data_bus_i[7:4], vec_q[3:0]};
    end
  end

  // acknowledged channel loses its pending bit
  always_comb begin
    clr_pend = 16'h0000;
    if (ack_pulse) begin
      clr_pend[top_code] = 1'b1;
    end
    if (wr_pulse && rsel_q == pbvi_pkg::RSEL_PEND_HI) begin
      clr_pend[15:8] = clr_pend[15:8] | ~data_bus_i;
    end
    if (wr_pulse && rsel_q == pbvi_pkg::RSEL_PEND_LO) begin
      clr_pend[7:0] = clr_pend[7:0] | ~data_bus_i;
    end
  end

  // pending bits; a new event wins over a clear in the same cycle
  // a low enable drops a held bit as well as blocking new events
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend_q <= 16'h0000;
    end else begin
      pend_q <= (pend_q & ~clr_pend & chan_enable_i) | chan_req;
    end
  end

  // mask registers, cleared at reset so all channels are masked
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mask_q <= 16'h0000;
    end else if (wr_pulse && rsel_q == pbvi_pkg::RSEL_MASK_HI) begin
      mask_q[15:8] <= data_bus_i;
    end else if (wr_pulse && rsel_q == pbvi_pkg::RSEL_MASK_LO) begin
      mask_q[7:0] <= data_bus_i;
    end
  end

  // read data mux; unmapped selects read zero
  always_comb begin
    rdata = 8'h00;
    unique case (rsel_q)
      pbvi_pkg::RSEL_VECTOR: rdata = vec_q;
      pbvi_pkg::RSEL_PEND_HI: rdata = pend_q[15:8];
      pbvi_pkg::RSEL_PEND_LO: rdata = pend_q[7:0];
      pbvi_pkg::RSEL_MASK_HI: rdata = mask_q[15:8];
      pbvi_pkg::RSEL_MASK_LO: rdata = mask_q[7:0];
      default: rdata = 8'h00;
    endcase
  end

  // data bus: read data or vector, driven at the edge that lowers ack
  // released as ack goes high, so the bus is off before ack floats
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_bus_o <= 8'h00;
      data_bus_oe_n_o <= 1'b1;
    end else if (state_q == pbvi_pkg::PBVI_DRIVE && rw_q) begin
      data_bus_oe_n_o <= 1'b0;
      if (!int_ack_n_s) begin
        data_bus_o <= {vec_q[7:4], top_code};
      end else begin
        data_bus_o <= rdata;
      end
    end else if (state_d != pbvi_pkg::PBVI_ACK) begin
      data_bus_oe_n_o <= 1'b1;
    end
  end

  // acknowledge: low in ack state, high for one cycle, then released
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      transfer_ack_n_o <= 1'b1;
      transfer_ack_oe_n_o <= 1'b1;
    end else begin
      unique case (state_d)
        pbvi_pkg::PBVI_ACK: begin
          transfer_ack_n_o <= 1'b0;
          transfer_ack_oe_n_o <= 1'b0;
        end
        pbvi_pkg::PBVI_HIGH: begin
          transfer_ack_n_o <= 1'b1;
          transfer_ack_oe_n_o <= 1'b0;
        end
        default: begin
          transfer_ack_n_o <= 1'b1;
          transfer_ack_oe_n_o <= 1'b1;
        end
      endcase
    end
  end

  // request output; rises once no unmasked pending bit remains
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_req_n_o <= 1'b1;
    end else begin
      int_req_n_o <= !any_live;
    end
  end

  // chain output passes priority only while passing
  // taken from the next state, so it moves together with the state
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chain_enable_out_n_o <= 1'b1;
    end else begin
      chain_enable_out_n_o <= state_d != pbvi_pkg::PBVI_PASS;
    end
  end

  // copy of the vector register for the far side
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vector_reg_o <= pbvi_pkg::VEC_RESET;
    end else begin
      vector_reg_o <= vec_q;
    end
  end
endmodule
